// file: dma_channel_defs.svh
// Constants of the four-channel DMA channel control block: register
// offsets, control field positions, reset values and request codes.
// Assumes inclusion by bare name from the block's source files.
`ifndef DMA_CHANNEL_DEFS_SVH
`define DMA_CHANNEL_DEFS_SVH

// Byte offsets: channel c register r sits at c*CH_STRIDE + r
`define OFS_SOURCE       8'h00
`define OFS_DEST         8'h04
`define OFS_COUNT        8'h08
`define OFS_CONTROL      8'h0c
`define CH_STRIDE        8'h10
`define OFS_OPERATION    8'h40

// Control register fields
`define CTL_DE           0
`define CTL_TE           1
`define CTL_IE           2
`define CTL_TS_LO        3
`define CTL_TM           5
`define CTL_DS           6
`define CTL_RS_LO        8
`define CTL_SM_LO        12
`define CTL_DM_LO        14
`define CTL_AL           16
`define CTL_DI           20
`define CTL_WIDTH        21
`define CTL_RESET        21'h00_0000

// Operation register fields
`define OP_DME           0
`define OP_ABORT_IRQ_FLAG          1
`define OP_AE            2
`define OP_PR_LO         8
`define OP_RESET         3'h0

// Step field and unit size codes
`define STEP_FIXED       2'h0
`define STEP_UP          2'h1
`define STEP_DOWN        2'h2
`define STEP_BAD         2'h3
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_LONG        2'h2
`define SIZE_BAD         2'h3

// Request source codes
`define RS_EXT_DUAL      4'h0
`define RS_BAD_A         4'h1
`define RS_EXT_MEM2DEV   4'h2
`define RS_EXT_DEV2MEM   4'h3
`define RS_AUTO          4'h4
`define RS_BAD_B         4'h5
`define RS_FIRST_PERIPH  4'h6

`define INDIRECT_STEP    32'h0000_0004

`endif

// file: dma_channel_pkg.sv
// Types shared by the DMA channel control block.
// Assumes the constants header is compiled alongside.
`default_nettype none
`include "dma_channel_defs.svh"

package dma_channel_pkg;

	typedef struct packed {
		logic [3:0][31:0]          src;
		logic [3:0][31:0]          dst;
		logic [3:0][23:0]          cnt;
		logic [3:0][`CTL_WIDTH-1:0] ctl;
		logic [3:0]                te_seen;
		logic [3:0]                pend;
		logic [3:0]                req;
		logic [1:0]                ack;
		logic [3:0]                irq;
		logic                      master_enable;
		logic                      abort_irq_flag;
		logic                      ae;
		logic                      abort_irq_flag_seen;
		logic                      ae_seen;
		logic [1:0]                prio;
		logic [31:0]               rdata;
		logic                      ready;
		logic                      slverr;
	} ctl_state_t;

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic low;
		logic fall;
	} sampler_state_t;

endpackage

`default_nettype wire

// file: req_pin_sampler.sv
// Request pin sampler: two-flop synchroniser, low level and falling edge.
// Assumes an asynchronous pin input, active low.
`timescale 1ns/1ps
`default_nettype none

module req_pin_sampler
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin_n,
	output logic      low_level,
	output logic      fall_pulse
);

	dma_channel_pkg::sampler_state_t s_r;
	dma_channel_pkg::sampler_state_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sync1 = pin_n;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		s_nxt.low = ~s_r.sync2;
		s_nxt.fall = s_r.prev & ~s_r.sync2;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, default: 1'b0};
		else
			s_r <= s_nxt;
	end

	assign low_level = s_r.low;
	assign fall_pulse = s_r.fall;

endmodule

`default_nettype wire

// file: dma_channel_control.sv
// Four-channel DMA channel control: registers, request selection,
// enable gating, address stepping, counting and completion.
// Assumes an APB master on pclk and a bus sequencer that pulses
// unit_done for a channel whose xfer_req is high.
//
// Functional notes
// - Ack polarity: 0 active high, 1 low
// - Destination step fixed, plus or minus size
// - Source step fixed, plus or minus size
// - Device-to-memory single mode ignores stepping
// - Channel 3 indirect pointer steps by four
// - Request codes: external, single, auto, prohibited
// - Codes six upward select peripheral events
// - External requests only on channels 0, 1
// - Sense bit: level or falling edge
// - Peripheral sources always edge; auto ignores sense
// - Bus mode: cycle steal or burst
// - Unit size byte, word or longword
// - Completion flag set when count runs out
// - Aborted transfer leaves completion flag clear
// - Completion flag set blocks all transfers; the code blocks only that flag's own channel
// - Flag cleared by zero after read one
// - Interrupt raised on completion when enabled
// - Auto request starts on channel enable
// - Other sources need request after enable
// - Clearing channel enable suspends transfer
// - Enable needs flags clear and master enable
// - Reserved bit seven reads zero
// - Control cleared by reset and standby only
// - Ack polarity only on channels 0, 1
// - Master and channel enable both required
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dma_channel_defs.svh"

module dma_channel_control
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              standby,
	input  wire logic [1:0]        ext_request_pin_n,
	output logic [1:0]             ext_ack_pin,
	input  wire logic [9:0]        periph_event,
	input  wire logic              abort_event,
	input  wire logic              addr_error_event,
	input  wire logic [3:0]        unit_done,
	output logic [3:0]             xfer_req,
	output logic [3:0]             burst_mode,
	output logic [3:0][1:0]        unit_size,
	output logic [3:0][31:0]       src_addr,
	output logic [3:0][31:0]       dst_addr,
	output logic                   ch3_indirect,
	output logic [3:0]             done_irq
);

	dma_channel_pkg::ctl_state_t s_r;
	dma_channel_pkg::ctl_state_t s_nxt;

	logic [1:0] pin_low;
	logic [1:0] pin_fall;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_pin
			req_pin_sampler u_sampler
			(
				.pclk       (pclk),
				.presetn    (presetn),
				.pin_n      (ext_request_pin_n[g]),
				.low_level  (pin_low[g]),
				.fall_pulse (pin_fall[g])
			);
		end
	endgenerate

	// Step amount for a field and a unit size
	function automatic logic [31:0] step_of(input logic [1:0] mode,
		input logic [31:0] amt);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (mode == `STEP_UP)
			r = amt;
		else if (mode == `STEP_DOWN)
			r = 32'h0000_0000 - amt;
		return r;
	endfunction

	// Keep old field when a prohibited code is written
	function automatic logic [1:0] keep2(input logic [1:0] old_v,
		input logic [1:0] new_v);
		keep2 = (new_v == 2'h3) ? old_v : new_v;
	endfunction

	always_comb
	begin
		logic            setup;
		logic            acc;
		logic            wr;
		logic            rd;
		logic            ch_area;
		logic [1:0]      ch_sel;
		logic [7:0]      reg_ofs;
		logic            hit;
		logic [31:0]     rval;
		logic [`CTL_WIDTH-1:0] c;
		logic [`CTL_WIDTH-1:0] w;
		logic            en;
		logic            is_ext;
		logic            ext_ok;
		logic            is_periph;
		logic            ev;
		logic            lvl;
		logic [3:0]      rs;
		logic [31:0]     amt;
		logic [31:0]     samt;
		logic            no_step;
		logic            done;
		logic [3:0]      pidx;
		setup = 1'b0;
		acc = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		ch_area = 1'b0;
		ch_sel = 2'h0;
		reg_ofs = 8'h00;
		hit = 1'b0;
		rval = 32'h0000_0000;
		c = '0;
		w = '0;
		en = 1'b0;
		is_ext = 1'b0;
		ext_ok = 1'b0;
		is_periph = 1'b0;
		ev = 1'b0;
		lvl = 1'b0;
		rs = 4'h0;
		amt = 32'h0000_0000;
		samt = 32'h0000_0000;
		no_step = 1'b0;
		done = 1'b0;
		pidx = 4'h0;
		s_nxt = s_r;
		s_nxt.ready = 1'b0;
		s_nxt.slverr = 1'b0;
		setup = psel & ~penable;
		acc = psel & penable & s_r.ready;
		wr = acc & pwrite;
		rd = acc & ~pwrite;
		ch_area = (paddr < `OFS_OPERATION);
		ch_sel = paddr[5:4];
		reg_ofs = paddr & 8'h0c;
		hit = (paddr[1:0] == 2'h0) &&
			(ch_area || paddr == `OFS_OPERATION);
		// Read data prepared in setup, answered in the access phase
		if (setup)
		begin
			s_nxt.ready = 1'b1;
			s_nxt.slverr = ~hit;
			if (hit && ch_area)
			begin
				case (reg_ofs)
					`OFS_SOURCE:  rval = s_r.src[ch_sel];
					`OFS_DEST:    rval = s_r.dst[ch_sel];
					`OFS_COUNT:   rval = {8'h00, s_r.cnt[ch_sel]};
					default:      rval = {11'h000, s_r.ctl[ch_sel]};
				endcase
			end
			else if (hit)
				rval = {22'h00_0000, s_r.prio, 5'h00, s_r.ae,
					s_r.abort_irq_flag, s_r.master_enable};
			s_nxt.rdata = rval;
		end
		// read of one arms the clear
		if (rd && ch_area && reg_ofs == `OFS_CONTROL &&
			s_r.ctl[ch_sel][`CTL_TE])
			s_nxt.te_seen[ch_sel] = 1'b1;
		if (rd && paddr == `OFS_OPERATION)
		begin
			s_nxt.abort_irq_flag_seen = s_r.abort_irq_flag;
			s_nxt.ae_seen = s_r.ae;
		end
		if (wr && hit && ch_area)
		begin
			c = s_r.ctl[ch_sel];
			w = pwdata[`CTL_WIDTH-1:0];
			case (reg_ofs)
				`OFS_SOURCE: s_nxt.src[ch_sel] = pwdata;
				`OFS_DEST:   s_nxt.dst[ch_sel] = pwdata;
				`OFS_COUNT:  s_nxt.cnt[ch_sel] = pwdata[23:0];
				default:
				begin
					c[`CTL_DE] = w[`CTL_DE];
					c[`CTL_IE] = w[`CTL_IE];
					c[`CTL_TM] = w[`CTL_TM];
					// prohibited codes keep the old value
					c[`CTL_TS_LO+:2] = keep2(c[`CTL_TS_LO+:2],
						w[`CTL_TS_LO+:2]);
					c[`CTL_SM_LO+:2] = keep2(c[`CTL_SM_LO+:2],
						w[`CTL_SM_LO+:2]);
					c[`CTL_DM_LO+:2] = keep2(c[`CTL_DM_LO+:2],
						w[`CTL_DM_LO+:2]);
					if (w[`CTL_RS_LO+:4] != `RS_BAD_A &&
						w[`CTL_RS_LO+:4] != `RS_BAD_B)
						c[`CTL_RS_LO+:4] = w[`CTL_RS_LO+:4];
					// only channels 0 and 1 keep these
					if (ch_sel < 2'h2)
					begin
						c[`CTL_DS] = w[`CTL_DS];
						c[`CTL_AL] = w[`CTL_AL];
					end
					if (ch_sel == 2'h3)
						c[`CTL_DI] = w[`CTL_DI];
					if (!w[`CTL_TE] && s_r.te_seen[ch_sel])
						c[`CTL_TE] = 1'b0;
					s_nxt.te_seen[ch_sel] = 1'b0;
					s_nxt.ctl[ch_sel] = c;
				end
			endcase
		end
		if (wr && paddr == `OFS_OPERATION)
		begin
			s_nxt.master_enable = pwdata[`OP_DME];
			s_nxt.prio = pwdata[`OP_PR_LO+:2];
			if (!pwdata[`OP_ABORT_IRQ_FLAG] && s_r.abort_irq_flag_seen)
				s_nxt.abort_irq_flag = 1'b0;
			if (!pwdata[`OP_AE] && s_r.ae_seen)
				s_nxt.ae = 1'b0;
			s_nxt.abort_irq_flag_seen = 1'b0;
			s_nxt.ae_seen = 1'b0;
		end
		// Abort flags: the set wins over a clear
		if (abort_event)
			s_nxt.abort_irq_flag = 1'b1;
		if (addr_error_event)
			s_nxt.ae = 1'b1;
		for (int ch = 0; ch < 4; ch++)
		begin
			c = s_nxt.ctl[ch];
			rs = c[`CTL_RS_LO+:4];
			en = c[`CTL_DE] & ~s_r.ctl[ch][`CTL_TE] & s_r.master_enable &
				~s_r.abort_irq_flag & ~s_r.ae;
			is_ext = (rs == `RS_EXT_DUAL) || (rs == `RS_EXT_MEM2DEV) ||
				(rs == `RS_EXT_DEV2MEM);
			// external codes honoured on channels 0 and 1
			ext_ok = is_ext && (ch < 2);
			is_periph = (rs >= `RS_FIRST_PERIPH);
			pidx = rs - `RS_FIRST_PERIPH;
			ev = 1'b0;
			lvl = 1'b0;
			// peripheral events act on their pulse
			if (is_periph)
				ev = periph_event[pidx];
			else if (ext_ok && c[`CTL_DS])
				ev = pin_fall[ch[0]];
			else if (ext_ok)
				lvl = pin_low[ch[0]];
			if (rs == `RS_AUTO)
				ev = 1'b1;
			case (c[`CTL_TS_LO+:2])
				`SIZE_WORD: amt = 32'h0000_0002;
				`SIZE_LONG: amt = 32'h0000_0004;
				default:    amt = 32'h0000_0001;
			endcase
			samt = (ch == 3 && c[`CTL_DI]) ? `INDIRECT_STEP : amt;
			// device to memory in single mode
			no_step = (rs == `RS_EXT_DEV2MEM) && ext_ok;
			done = unit_done[ch] & s_r.req[ch];
			if (!en)
			begin
				s_nxt.pend[ch] = 1'b0;
				s_nxt.req[ch] = 1'b0;
			end
			else
			begin
				// only requests seen while enabled count
				if (ev)
					s_nxt.pend[ch] = 1'b1;
				// cycle steal drops the request per unit
				else if (done && !c[`CTL_TM])
					s_nxt.pend[ch] = 1'b0;
				s_nxt.req[ch] = s_nxt.pend[ch] | lvl;
			end
			if (done)
			begin
				if (!no_step)
				begin
					s_nxt.src[ch] = s_nxt.src[ch] +
						step_of(c[`CTL_SM_LO+:2], samt);
					s_nxt.dst[ch] = s_nxt.dst[ch] +
						step_of(c[`CTL_DM_LO+:2], amt);
				end
				s_nxt.cnt[ch] = s_r.cnt[ch] - 24'h00_0001;
				if (s_r.cnt[ch] == 24'h00_0001)
				begin
					s_nxt.ctl[ch][`CTL_TE] = 1'b1;
					s_nxt.pend[ch] = 1'b0;
					s_nxt.req[ch] = 1'b0;
				end
			end
			s_nxt.irq[ch] = s_nxt.ctl[ch][`CTL_TE] &
				s_nxt.ctl[ch][`CTL_IE];
			if (ch < 2)
				s_nxt.ack[ch[0]] = s_nxt.req[ch] ^ c[`CTL_AL];
		end
		// standby clears control and operation state
		if (standby)
		begin
			s_nxt = '{src: s_nxt.src, dst: s_nxt.dst, cnt: s_nxt.cnt,
				rdata: s_nxt.rdata, ready: s_nxt.ready,
				slverr: s_nxt.slverr, default: '0};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign prdata = s_r.rdata;
	assign pready = s_r.ready;
	assign pslverr = s_r.slverr;
	assign ext_ack_pin = s_r.ack;
	assign xfer_req = s_r.req;
	assign src_addr = s_r.src;
	assign dst_addr = s_r.dst;
	assign done_irq = s_r.irq;
	assign ch3_indirect = s_r.ctl[3][`CTL_DI];

	generate
		for (g = 0; g < 4; g++)
		begin : g_out
			assign burst_mode[g] = s_r.ctl[g][`CTL_TM];
			assign unit_size[g] = s_r.ctl[g][`CTL_TS_LO+:2];
		end
	endgenerate

endmodule

`default_nettype wire

// file: dma_far_side_model.sv
// Far side: an external requester on the pins and a bus sequencer.
// Assumes pull-ups on the request pins; stall holds the sequencer off.
`timescale 1ns/1ps
`default_nettype none

module dma_far_side_model
(
	input	wire logic	pclk,
	input	wire logic	presetn,
	input	wire logic [1:0]	fire,
	input	wire logic [1:0]	ack_on,
	input	wire logic [1:0]	ack,
	input	wire logic [3:0]	xfer_req,
	input	wire logic	stall,
	output	logic [1:0]	req_n,
	output	logic [3:0]	unit_done
);
	logic [3:0]	pulse_r;

	assign unit_done = pulse_r & xfer_req;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_n <= 2'b11;
			pulse_r <= 4'h0;
		end
		else
		begin
			// Pin falls on command, back to pull-up once acknowledged
			req_n <= (req_n & ~fire) | (~req_n & ~(ack ^ ack_on));
			pulse_r <= xfer_req & ~pulse_r & {4{~stall}};
		end
	end
endmodule

`default_nettype wire

// file: dma_channel_control_asserts.sv
// Port checker for the DMA channel control block.
// Assumes it is bound to the block and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_control_asserts
(
	input	wire logic	pclk,
	input	wire logic	presetn,
	input	wire logic	psel,
	input	wire logic	standby,
	input	wire logic	abort_event,
	input	wire logic	addr_error_event,
	input	wire logic [3:0]	unit_done,
	input	wire logic [3:0]	xfer_req,
	input	wire logic [3:0][31:0]	src_addr,
	input	wire logic [3:0][31:0]	dst_addr,
	input	wire logic [3:0]	done_irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_standby_req: assert property (
		standby |=> xfer_req == 4'h0) else $error("request after standby");
	a_standby_flag: assert property (
		standby |=> done_irq == 4'h0) else $error("flag after standby");
	a_abort_stops: assert property (
		abort_event |-> ##3 xfer_req == 4'h0) else $error("abort ignored");
	a_addr_err_stops: assert property (
		addr_error_event |-> ##3 xfer_req == 4'h0)
		else $error("address error ignored");
	a_src_hold: assert property (
		!psel && unit_done == 4'h0 |=> $stable(src_addr))
		else $error("source moved without a unit");
	a_dst_hold: assert property (
		!psel && unit_done == 4'h0 |=> $stable(dst_addr))
		else $error("destination moved without a unit");
	a_done_blocks: assert property (
		(done_irq & xfer_req) == 4'h0) else $error("request while done");
	a_irq_cause: assert property (
		$rose(done_irq[0]) |-> $past(unit_done[0] || psel))
		else $error("interrupt without cause");

	c_unit: cover property (unit_done[0]);
	c_abort: cover property (abort_event && xfer_req != 4'h0);
	c_done: cover property ($rose(done_irq[1]));
endmodule

`default_nettype wire

// file: dma_channel_control_tb_top.sv
// Testbench: register access over APB and transfers on channels 0, 1 and 3.
// Assumes the far-side model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module dma_channel_control_tb_top;
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata, rv;
	logic	standby, abort_ev, aerr_ev, ind, stall, err;
	logic [1:0]	req_n, ack, fire, ack_on;
	logic [9:0]	pev;
	logic [3:0]	udone, xreq, bmode, irq;
	logic [3:0][1:0]	usize;
	logic [3:0][31:0]	src, dst;
	int	miscompares, cmp_count, cycles, k;

	dma_channel_control i_dma_channel_control (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby(standby), .ext_request_pin_n(req_n),
		.ext_ack_pin(ack), .periph_event(pev), .abort_event(abort_ev),
		.addr_error_event(aerr_ev), .unit_done(udone), .xfer_req(xreq),
		.burst_mode(bmode), .unit_size(usize), .src_addr(src),
		.dst_addr(dst), .ch3_indirect(ind), .done_irq(irq));
	dma_far_side_model i_dma_far_side_model (.pclk(pclk),
		.presetn(presetn), .fire(fire), .ack_on(ack_on), .ack(ack),
		.xfer_req(xreq), .stall(stall), .req_n(req_n),
		.unit_done(udone));

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			test_done;
		end
	end

	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk("reg", rv, e);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// Loads addresses and count, arms, enables, kicks and waits for done
	task automatic run(input logic [1:0] c, input logic [31:0] ctl,
		input logic [23:0] n, input logic [10:0] ev);
		logic [7:0]	b;
		int	t;
		b = {2'b00, c, 4'h0};
		apb(1'b1, b, 32'h0000_1000);
		apb(1'b1, b + 8'h04, 32'h0000_2000);
		apb(1'b1, b + 8'h08, {8'h00, n});
		apb(1'b0, b + 8'h0c, 32'h0000_0000);
		apb(1'b1, b + 8'h0c, ctl);
		tick(4);
		fire <= {1'b0, ev[10]};
		pev <= ev[9:0];
		tick(1);
		fire <= 2'b00;
		pev <= 10'h000;
		t = 0;
		while (irq[c] !== 1'b1 && t < 200)
		begin
			tick(1);
			t++;
		end
		chk("irq", 32'(irq[c]), 32'h0000_0001);
	endtask

	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, standby, abort_ev, aerr_ev} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pev = 10'h000;
		fire = 2'b00;
		ack_on = 2'b11;
		stall = 1'b0;
		tick(6);
		presetn <= 1'b1;
		rdc(8'h0c, 32'h0000_0000);
		rdc(8'h40, 32'h0000_0000);
		$display("test reset done");
		apb(1'b1, 8'h0c, 32'h0001_6476);
		rdc(8'h0c, 32'h0001_6474);
		tick(2);
		chk("ack", 32'(ack), 32'h0000_0001);
		apb(1'b1, 8'h2c, 32'h0001_6476);
		rdc(8'h2c, 32'h0000_6434);
		apb(1'b1, 8'h0c, 32'h0000_f118);
		rdc(8'h0c, 32'h0000_6410);
		apb(1'b0, 8'h44, 32'h0000_0000);
		chk("slverr", 32'(err), 32'h0000_0001);
		$display("test fields done");
		apb(1'b1, 8'h40, 32'h0000_0001);
		run(2'd0, 32'h0000_6405, 24'h2, 11'h000);
		chk("src", src[0], 32'h0000_0ffe);
		chk("dst", dst[0], 32'h0000_2002);
		run(2'd0, 32'h0000_942d, 24'h1, 11'h000);
		chk("src", src[0], 32'h0000_1002);
		chk("dst", dst[0], 32'h0000_1ffe);
		chk("mode", {bmode[0], 29'h0, usize[0]}, 32'h8000_0001);
		run(2'd0, 32'h0000_1415, 24'h1, 11'h000);
		chk("src", src[0], 32'h0000_1004);
		chk("dst", dst[0], 32'h0000_2000);
		run(2'd3, 32'h0010_2405, 24'h1, 11'h000);
		chk("src", src[3], 32'h0000_0ffc);
		chk("ind", 32'(ind), 32'h0000_0001);
		run(2'd0, 32'h0000_120d, 24'h1, 11'h400);
		chk("src", src[0], 32'h0000_1002);
		ack_on <= 2'b10;
		run(2'd0, 32'h0001_5345, 24'h1, 11'h400);
		chk("src", src[0], 32'h0000_1000);
		chk("dst", dst[0], 32'h0000_2000);
		chk("ack", 32'(ack), 32'h0000_0001);
		for (k = 0; k < 10; k++)
		begin
			run(2'd1, 32'h0000_1005 | (k + 6) << 8, 24'h1, 11'(1 << k));
			chk("src", src[1], 32'h0000_1001);
		end
		run(2'd1, 32'h0000_1625, 24'h2, 11'h001);
		chk("src", src[1], 32'h0000_1002);
		$display("test transfers done");
		apb(1'b1, 8'h0c, 32'h0001_5344);
		rdc(8'h0c, 32'h0001_5346);
		apb(1'b1, 8'h0c, 32'h0001_5346);
		rdc(8'h0c, 32'h0001_5346);
		apb(1'b1, 8'h0c, 32'h0001_5344);
		rdc(8'h0c, 32'h0001_5344);
		chk("irq", 32'(irq[0]), 32'h0000_0000);
		$display("test flag done");
		stall <= 1'b1;
		apb(1'b1, 8'h40, 32'h0000_0000);
		apb(1'b0, 8'h1c, 32'h0000_0000);
		apb(1'b1, 8'h1c, 32'h0000_0405);
		tick(4);
		chk("req", 32'(xreq[1]), 32'h0000_0000);
		apb(1'b1, 8'h40, 32'h0000_0001);
		tick(4);
		chk("req", 32'(xreq[1]), 32'h0000_0001);
		apb(1'b1, 8'h1c, 32'h0000_0404);
		tick(3);
		chk("req", 32'(xreq[1]), 32'h0000_0000);
		apb(1'b1, 8'h1c, 32'h0000_0405);
		tick(1);
		abort_ev <= 1'b1;
		aerr_ev <= 1'b1;
		tick(1);
		abort_ev <= 1'b0;
		aerr_ev <= 1'b0;
		tick(4);
		chk("req", 32'(xreq[1]), 32'h0000_0000);
		rdc(8'h40, 32'h0000_0007);
		rdc(8'h1c, 32'h0000_0405);
		apb(1'b1, 8'h40, 32'h0000_0001);
		tick(4);
		chk("req", 32'(xreq[1]), 32'h0000_0001);
		apb(1'b1, 8'h2c, 32'h0000_0001);
		tick(4);
		chk("req", 32'(xreq[2]), 32'h0000_0000);
		$display("test enable done");
		standby <= 1'b1;
		tick(2);
		standby <= 1'b0;
		rdc(8'h1c, 32'h0000_0000);
		rdc(8'h40, 32'h0000_0000);
		stall <= 1'b0;
		$display("test standby done");
		test_done;
	end
endmodule

bind dma_channel_control dma_channel_control_asserts
	i_dma_channel_control_asserts (.pclk(pclk), .presetn(presetn),
	.psel(psel), .standby(standby), .abort_event(abort_event),
	.addr_error_event(addr_error_event), .unit_done(unit_done),
	.xfer_req(xfer_req), .src_addr(src_addr), .dst_addr(dst_addr),
	.done_irq(done_irq));

`default_nettype wire
